// ### inc/vol_ramp_pkg.sv
// shared constants and types for the volume step ramp control
package vol_ramp_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  localparam int TICK_HZ = 60;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int TICK_W = 20;
  localparam logic [1:0] TICKS_PER_STEP = 2'h3; // last of four ticks
  localparam int FAST_WINDOW_NS = 1_000_000;
  localparam int LEVELS = 33;
  // longest time rounds down so the whole fast ramp fits in the window
  localparam int FAST_STEP_CYC = FAST_WINDOW_NS / CLK_NS / LEVELS;
  localparam int FAST_W = 11;
  localparam int CODE_W = 8;
  localparam int THR_W = 9;
  localparam int STEP_W = 5;
  localparam int LVL_W = 6;
  localparam logic [LVL_W-1:0] MUTE_LVL = 6'h00;
  localparam logic [STEP_W-1:0] MAX_STEP = 5'h1F;
  localparam logic [STEP_W-1:0] MIN_STEP = 5'h00;
  localparam logic [THR_W-1:0] TRIP_PITCH = 9'h008;
  localparam logic [THR_W-1:0] TRIP_HYST = 9'h003;
  localparam logic [THR_W-1:0] THR_NEVER = 9'h100;
  localparam logic [THR_W-1:0] THR_ZERO = 9'h000;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_FALL = 2'b10
  } ramp_state_t;
endpackage

// ### verilog/trip_table.sv
// registered lookup of the rising and falling trip points around a step
`timescale 1ns/1ps
module trip_table
  import vol_ramp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [STEP_W-1:0] step_idx,
  output logic [THR_W-1:0] rise_thr_r,
  output logic [THR_W-1:0] fall_thr_r
);
  logic [THR_W-1:0] rise_nxt;
  logic [THR_W-1:0] fall_nxt;
  logic [THR_W-1:0] idx_w;

  always_comb begin
    idx_w = {{(THR_W-STEP_W){1'b0}}, step_idx};
    // top step has no upward trip; bottom step has no downward trip
    if (step_idx == MAX_STEP) begin
      rise_nxt = THR_NEVER;
    end else begin
      rise_nxt = THR_W'((idx_w + 9'h001) * TRIP_PITCH);
    end
    if (step_idx == MIN_STEP) begin
      fall_nxt = THR_ZERO;
    end else begin
      fall_nxt = THR_W'(idx_w * TRIP_PITCH - TRIP_HYST);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rise_thr_r <= TRIP_PITCH;
      fall_thr_r <= THR_ZERO;
    end else begin
      rise_thr_r <= rise_nxt;
      fall_thr_r <= fall_nxt;
    end
  end
endmodule

// ### verilog/vol_ramp_ctrl.sv
// gain step selection, timed gain ramps, fade, mute, shutdown and short latch
`timescale 1ns/1ps
// What this block does
// - target step comes from volume code, a fraction of reference, via trip table
// - rising and falling trip points differ, so selection never oscillates
// - gain moves one step per four ticks of a 60 Hz tick, except on no-fade power-up and shutdown ramps
// - fade mode: leaving shutdown, gain climbs from mute level to target
// - fade mode: shutdown low steps gain down to mute, then shuts down
// - no fade: mute level to target in under 1 ms
// - no fade: shutdown low reaches mute level within 1 ms
// - mute high disables outputs, low enables them
// - mute acts at once, with no ramp, in either mode
// - shutdown low mutes and enters minimum current state
// - a short latches outputs off until shutdown goes low
module vol_ramp_ctrl
  import vol_ramp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [CODE_W-1:0] volume_code,
  input wire logic shutdown_n,
  input wire logic mute,
  input wire logic fade_n,
  input wire logic short_detect,
  output logic [LVL_W-1:0] gain_level_r,
  output logic [STEP_W-1:0] target_step_r,
  output logic out_enable_r,
  output logic low_power_r,
  output logic short_latched_r
);
  // pin synchronisers; the volume code is expected to move slowly, so a
  // torn sample only costs one extra cycle of settling
  logic [CODE_W-1:0] vol_s1, vol_s2;
  logic sd_s1, sd_s2, mute_s1, mute_s2, fade_s1, fade_s2, sh_s1, sh_s2;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vol_s1 <= '0;
      vol_s2 <= '0;
      {sd_s1, sd_s2, mute_s1, mute_s2} <= 4'h0;
      {fade_s1, fade_s2, sh_s1, sh_s2} <= 4'h0;
    end else begin
      vol_s1 <= volume_code;
      vol_s2 <= vol_s1;
      {sd_s1, sd_s2} <= {shutdown_n, sd_s1};
      {mute_s1, mute_s2} <= {mute, mute_s1};
      {fade_s1, fade_s2} <= {fade_n, fade_s1};
      {sh_s1, sh_s2} <= {short_detect, sh_s1};
    end
  end

  // target selection with hysteresis
  logic [THR_W-1:0] rise_thr, fall_thr, vol_w;
  logic tbl_ok_r, tbl_ok_nxt;
  logic [STEP_W-1:0] target_nxt;

  trip_table u_trip (
    .sys_clk(sys_clk),
    .srst(srst),
    .step_idx(target_step_r),
    .rise_thr_r(rise_thr),
    .fall_thr_r(fall_thr)
  );

  always_comb begin
    vol_w = {1'b0, vol_s2};
    target_nxt = target_step_r;
    tbl_ok_nxt = 1'b1;
    // table lags the index one cycle, so decide only on fresh thresholds
    if (tbl_ok_r) begin
      if (vol_w >= rise_thr) begin
        target_nxt = target_step_r + 5'h01;
        tbl_ok_nxt = 1'b0;
      end else if (vol_w < fall_thr) begin
        target_nxt = target_step_r - 5'h01;
        tbl_ok_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      target_step_r <= MIN_STEP;
      tbl_ok_r <= 1'b0;
    end else begin
      target_step_r <= target_nxt;
      tbl_ok_r <= tbl_ok_nxt;
    end
  end

  // 60 Hz tick and step pacing
  logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  logic [1:0] slow_cnt_r, slow_cnt_nxt;
  logic [FAST_W-1:0] fast_cnt_r, fast_cnt_nxt;
  logic fast_r, fast_nxt, step_due;
  ramp_state_t state_r, state_nxt;
  logic [LVL_W-1:0] desired, level_nxt;
  logic short_nxt, oen_nxt, lowp_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 20'h00001;
    if (tick_cnt_r == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    fast_nxt = fast_r;
    desired = MUTE_LVL;
    case (state_r)
      ST_OFF: begin
        if (sd_s2) begin
          state_nxt = ST_RUN;
          fast_nxt = fade_s2;
        end
      end
      ST_RUN: begin
        desired = {1'b0, target_step_r} + 6'h01;
        if (!sd_s2) begin
          state_nxt = ST_FALL;
          fast_nxt = fade_s2;
        end else if (gain_level_r == desired) begin
          fast_nxt = 1'b0; // volume changes after power-up are always slow
        end
      end
      ST_FALL: begin
        if (sd_s2) begin
          state_nxt = ST_RUN;
        end else if (gain_level_r == MUTE_LVL) begin
          state_nxt = ST_OFF;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  always_comb begin
    slow_cnt_nxt = slow_cnt_r;
    fast_cnt_nxt = fast_cnt_r + 11'h001;
    step_due = 1'b0;
    level_nxt = gain_level_r;
    if (fast_r) begin
      step_due = (fast_cnt_r == FAST_W'(FAST_STEP_CYC - 1));
    end else begin
      step_due = tick_r && (slow_cnt_r == TICKS_PER_STEP);
    end
    if (tick_r) begin
      slow_cnt_nxt = slow_cnt_r + 2'h1;
    end
    if (gain_level_r == desired) begin
      slow_cnt_nxt = 2'h0;
      fast_cnt_nxt = '0;
    end else if (step_due) begin
      fast_cnt_nxt = '0;
      slow_cnt_nxt = 2'h0;
      // only ever one step; target is re-read before the next one
      if (gain_level_r < desired) begin
        level_nxt = gain_level_r + 6'h01;
      end else begin
        level_nxt = gain_level_r - 6'h01;
      end
    end
    if (state_r == ST_OFF) begin
      level_nxt = MUTE_LVL;
    end
    // set wins over clear; clears only while shutdown is held low
    short_nxt = sh_s2 | (short_latched_r & sd_s2);
    oen_nxt = (state_r != ST_OFF) && !mute_s2 && !short_latched_r;
    lowp_nxt = (state_r == ST_OFF);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      slow_cnt_r <= 2'h0;
      fast_cnt_r <= '0;
      fast_r <= 1'b0;
      state_r <= ST_OFF;
      gain_level_r <= MUTE_LVL;
      short_latched_r <= 1'b0;
      out_enable_r <= 1'b0;
      low_power_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      slow_cnt_r <= slow_cnt_nxt;
      fast_cnt_r <= fast_cnt_nxt;
      fast_r <= fast_nxt;
      state_r <= state_nxt;
      gain_level_r <= level_nxt;
      short_latched_r <= short_nxt;
      out_enable_r <= oen_nxt;
      low_power_r <= lowp_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  target_rise_a: assert property (
    tbl_ok_r && vol_w >= rise_thr |=> target_step_r == $past(target_step_r) + 5'h01)
    else $error("target did not rise past trip point");
  hyst_hold_a: assert property (
    tbl_ok_r && vol_w < rise_thr && vol_w >= fall_thr |=> $stable(target_step_r))
    else $error("target moved inside hysteresis band");
  slow_pace_a: assert property (
    !$past(fast_r) && $past(state_r) != ST_OFF && $changed(gain_level_r)
      |-> $past(tick_r) && $past(slow_cnt_r) == TICKS_PER_STEP)
    else $error("slow step off the fourth tick");
  one_step_a: assert property (
    $past(state_r) != ST_OFF |-> gain_level_r - $past(gain_level_r) <= 6'h01
      || $past(gain_level_r) - gain_level_r <= 6'h01)
    else $error("gain jumped more than one step");
  wake_mute_a: assert property (
    state_r == ST_OFF && sd_s2 |=> state_r == ST_RUN && gain_level_r == MUTE_LVL)
    else $error("wake did not start at mute level");
  fall_down_a: assert property (
    state_r == ST_FALL && !sd_s2 |=> gain_level_r <= $past(gain_level_r))
    else $error("gain rose while falling to shutdown");
  fast_pace_a: assert property (
    fast_r && step_due && gain_level_r != desired |=> $changed(gain_level_r))
    else $error("fast step not taken");
  fast_fall_a: assert property (
    state_r == ST_RUN && !sd_s2 && fade_s2 |=> fast_r ##1 fast_r)
    else $error("fast shutdown ramp not selected");
  mute_now_a: assert property (
    mute_s2 |=> !out_enable_r)
    else $error("outputs enabled while muted");
  unmute_now_a: assert property (
    !mute_s2 && state_r == ST_RUN && !short_latched_r |=> out_enable_r)
    else $error("unmute delayed");
  off_state_a: assert property (
    state_r == ST_OFF |=> low_power_r && !out_enable_r)
    else $error("shutdown state not low power");
  short_hold_a: assert property (
    short_latched_r && sd_s2 |=> short_latched_r ##1 !out_enable_r)
    else $error("short latch cleared without shutdown");

  fade_ramp_c: cover property (state_r == ST_RUN && !fast_r && step_due);
  fast_wake_c: cover property (state_r == ST_OFF ##1 state_r == ST_RUN && fast_r);
  fall_off_c: cover property (state_r == ST_FALL ##1 state_r == ST_OFF);
  short_c: cover property (short_latched_r ##1 !short_latched_r);
endmodule

// ### verif/host_ctrl_model.sv
// host controller model driving the volume and control pins
`timescale 1ns/1ps
module host_ctrl_model
  import vol_ramp_pkg::*;
(
  input wire logic sys_clk,
  output logic [CODE_W-1:0] volume_code,
  output logic shutdown_n,
  output logic mute,
  output logic fade_n,
  output logic short_detect
);
  // every pin at a defined level from time zero, none floats
  initial begin
    volume_code = 8'h00;
    shutdown_n = 1'b0;
    mute = 1'b0;
    fade_n = 1'b0;
    short_detect = 1'b0;
  end
  // an 8-bit code cannot exceed the reference
  task automatic set_vol(input logic [CODE_W-1:0] c);
    @(posedge sys_clk);
    volume_code <= c;
  endtask
  task automatic set_pins(input logic sd, input logic mu, input logic fd,
                          input logic sh);
    @(posedge sys_clk);
    shutdown_n <= sd;
    mute <= mu;
    fade_n <= fd;
    short_detect <= sh;
  endtask
endmodule

// ### verif/vol_ramp_ctrl_tb.sv
// self-checking bench for the volume step ramp control
`timescale 1ns/1ps
module vol_ramp_ctrl_tb;
  import vol_ramp_pkg::*;
  // short tick keeps the slow ramp cheap to simulate
  localparam int TK = 8;
  localparam int GAP = 4 * TK;
  logic sys_clk;
  logic srst;
  logic [CODE_W-1:0] volume_code;
  logic shutdown_n, mute, fade_n, short_detect;
  logic [LVL_W-1:0] gain_level_r;
  logic [LVL_W-1:0] prev;
  logic [CODE_W-1:0] vc;
  logic [STEP_W-1:0] exp_step;
  logic [STEP_W-1:0] target_step_r;
  logic out_enable_r, low_power_r, short_latched_r;
  int errors = 0;
  int checks_done = 0;
  host_ctrl_model h (.sys_clk(sys_clk), .volume_code(volume_code),
    .shutdown_n(shutdown_n), .mute(mute), .fade_n(fade_n),
    .short_detect(short_detect));
  vol_ramp_ctrl #(.TICK_CYCLES(TK)) vol_ramp_ctrl_inst (.sys_clk(sys_clk),
    .srst(srst), .volume_code(volume_code), .shutdown_n(shutdown_n),
    .mute(mute), .fade_n(fade_n), .short_detect(short_detect),
    .gain_level_r(gain_level_r), .target_step_r(target_step_r),
    .out_enable_r(out_enable_r), .low_power_r(low_power_r),
    .short_latched_r(short_latched_r));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic fail(input string m);
    errors++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  task automatic check_lvl(input logic [LVL_W-1:0] g, e);
    checks_done++;
    if (g !== e) fail($sformatf("gain %0h exp %0h", g, e));
  endtask
  task automatic check_step(input logic [STEP_W-1:0] g, e);
    checks_done++;
    if (g !== e) fail($sformatf("target %0h exp %0h", g, e));
  endtask
  task automatic check_bit(input logic g, e);
    checks_done++;
    if (g !== e) fail($sformatf("flag %b exp %b", g, e));
  endtask
  task automatic check_cnt(input int g, e);
    checks_done++;
    if (g != e) fail($sformatf("interval %0d exp %0d", g, e));
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // sample one step after the edge so the design's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_lvl(input logic [LVL_W-1:0] e, input int lim);
    int n;
    n = 0;
    while (gain_level_r !== e && n < lim) begin
      tick(1);
      n++;
    end
    check_lvl(gain_level_r, e);
  endtask
  // first step may come early, later ones keep the full interval
  task automatic steps(input int k, input logic [LVL_W-1:0] dir);
    logic [LVL_W-1:0] p;
    int n;
    for (int i = 0; i < k; i++) begin
      p = gain_level_r;
      n = 0;
      while (gain_level_r === p && n < 2 * GAP) begin
        tick(1);
        n++;
      end
      check_lvl(gain_level_r, p + dir);
      if (i > 0) check_cnt(n, GAP);
    end
  endtask
  always @(posedge sys_clk) begin
    if (!srst && gain_level_r !== prev && gain_level_r !== prev + 6'h01
        && gain_level_r !== prev - 6'h01) fail("gain jumped");
    prev <= gain_level_r;
  end
  initial begin
    repeat (95000) @(posedge sys_clk);
    fail("watchdog expired");
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    tick(3);
    check_lvl(gain_level_r, MUTE_LVL);
    check_bit(low_power_r, 1'b1);
    @(posedge sys_clk);
    srst <= 1'b0;
    h.set_vol(8'h64);
    tick(40);
    check_step(target_step_r, 5'h0C);
    h.set_vol(8'h5A);
    tick(40);
    check_step(target_step_r, 5'h0B);
    h.set_vol(8'h5F);
    tick(40);
    check_step(target_step_r, 5'h0B);
    // falling sweep: each code sits at or just above one falling trip point
    for (int i = 0; i < 4; i++) begin
      vc = CODE_W'(8'h50 - i * 8'h09);
      h.set_vol(vc);
      tick(12);
      exp_step = STEP_W'((vc + TRIP_HYST) / TRIP_PITCH);
      check_step(target_step_r, exp_step);
    end
    h.set_vol(8'h1C);
    tick(40);
    check_step(target_step_r, 5'h03);
    h.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    steps(4, 6'h01);
    check_bit(low_power_r, 1'b0);
    h.set_vol(8'h3C);
    steps(4, 6'h01);
    h.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
    tick(4);
    check_bit(out_enable_r, 1'b0);
    check_lvl(gain_level_r, 6'h08);
    h.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    tick(4);
    check_bit(out_enable_r, 1'b1);
    h.set_pins(1'b1, 1'b0, 1'b0, 1'b1);
    tick(5);
    check_bit(short_latched_r, 1'b1);
    check_bit(out_enable_r, 1'b0);
    h.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    tick(20);
    check_bit(short_latched_r, 1'b1);
    h.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    steps(8, 6'h3F);
    tick(4);
    check_bit(low_power_r, 1'b1);
    check_bit(short_latched_r, 1'b0);
    h.set_vol(8'hFF);
    h.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    wait_lvl(6'h20, 40000);
    check_bit(out_enable_r, 1'b1);
    h.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
    wait_lvl(MUTE_LVL, 40000);
    tick(4);
    check_bit(low_power_r, 1'b1);
    give_verdict();
  end
endmodule
